// ---- core/rtcl_pkg.sv ----
`default_nettype none
package rtcl_pkg;
	// ========================================
	// widths and scaling
	localparam int TEMP_W = 16; // one lsb is 0.01 K, two's complement
	localparam int ERR_W = 19; // room for set point plus widened dead zone
	localparam logic [6:0] FULL_PCT = 7'h64; // 100 percent

	// ========================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int UPDATE_US = 1000; // control law update period
	localparam int UPDATE_CYC = UPDATE_US * CLK_MHZ;

	// ========================================
	// stage control types
	typedef enum logic [1:0] {RTCL_TWO_POINT, RTCL_PROP, RTCL_PI} rtcl_mode_e;

	// ========================================
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SETPT = 8'h04;
	localparam logic [7:0] A_ACTUAL = 8'h08;
	localparam logic [7:0] A_BAND = 8'h0C;
	localparam logic [7:0] A_TINT = 8'h10;
	localparam logic [7:0] A_DEADZ = 8'h14;
	localparam logic [7:0] A_HYST_HEAT = 8'h18;
	localparam logic [7:0] A_HYST_COOL = 8'h1C;
	localparam logic [7:0] A_HYST_ADD = 8'h20;
	localparam logic [7:0] A_ADD_OFS = 8'h24;
	localparam logic [7:0] A_STATUS = 8'h28;
	localparam logic [7:0] A_OUT_PCT = 8'h2C;
	localparam logic [7:0] A_COOL_SP = 8'h30;

	// ========================================
	// field positions
	localparam int CTRL_W = 10;
	localparam int CTRL_HM_LSB = 0;
	localparam int CTRL_CM_LSB = 2;
	localparam int CTRL_AM_LSB = 4;
	localparam int CTRL_EN_BIT = 8;
	localparam int CTRL_ADD_EN_BIT = 9;
	localparam int ST_HEAT_ON = 0;
	localparam int ST_COOL_ON = 1;
	localparam int ST_ADD_ON = 2;
	localparam int ST_HEAT_ZONE = 3;
	localparam int ST_COOL_ZONE = 4;
	localparam int ST_DEAD_ZONE = 5;
	localparam int OUT_HEAT_LSB = 0;
	localparam int OUT_COOL_LSB = 8;
	localparam int OUT_ADD_LSB = 16;

	// ========================================
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h308;
	localparam logic [15:0] SETPT_RST = 16'h0834;
	localparam logic [15:0] ACTUAL_RST = 16'h0834;
	localparam logic [15:0] BAND_RST = 16'h0190;
	localparam logic [15:0] TINT_RST = 16'h00B4;
	localparam logic [15:0] DEADZ_RST = 16'h0190;
	localparam logic [15:0] HH_RST = 16'h0064;
	localparam logic [15:0] HC_RST = 16'hFF9C;
	localparam logic [15:0] HA_RST = 16'hFFCE;
	localparam logic [15:0] ADD_OFS_RST = 16'h0064;

	// ========================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rtcl_pkg
`default_nettype wire

// ---- core/rtcl_stage.sv ----
`default_nettype none
module rtcl_stage (
	// clock and reset
	input  wire logic                               clk_sys,
	input  wire logic                               srst,
	// control
	input  wire logic                               tick,
	input  wire logic                               enable,
	input  wire rtcl_pkg::rtcl_mode_e               mode,
	input  wire logic signed [rtcl_pkg::ERR_W-1:0]  err,
	input  wire logic [15:0]                        band,
	input  wire logic [15:0]                        tint,
	input  wire logic [15:0]                        hyst,
	input  wire logic                               late,
	// result
	output logic [6:0]                              pct,
	output logic                                    on
);
	// ========================================
	// proportional law, saturating
	function automatic logic [6:0] prop_pct(input logic [rtcl_pkg::ERR_W-1:0] e_mag,
		input logic [15:0] bw);
		logic [25:0] num;
		num = 26'(e_mag) * 26'(rtcl_pkg::FULL_PCT);
		if (bw == 16'h0000 || e_mag >= rtcl_pkg::ERR_W'(bw))
			return rtcl_pkg::FULL_PCT;
		return 7'(num / 26'(bw));
	endfunction : prop_pct

	logic                              e_pos;
	logic                              e_neg;
	logic [rtcl_pkg::ERR_W-1:0]        e_mag;
	logic signed [rtcl_pkg::ERR_W-1:0] hyst_s;
	logic [6:0]                        p_mag;
	logic [6:0]                        p_pos;
	logic [16:0]                       sum;
	logic [16:0]                       sum_add;
	logic [6:0]                        integ;
	logic [7:0]                        pi_sum;
	logic [16:0]                       next_sum;
	logic [6:0]                        next_integ;
	logic [6:0]                        next_pct;
	logic                              next_on;

	// ========================================
	// deviation decode
	assign e_neg = err[rtcl_pkg::ERR_W-1];
	assign e_pos = !e_neg && (err != '0);
	assign e_mag = e_neg ? rtcl_pkg::ERR_W'(-err) : rtcl_pkg::ERR_W'(err);
	assign hyst_s = $signed({3'h0, hyst});
	assign p_mag = prop_pct(e_mag, band);
	assign p_pos = e_pos ? p_mag : 7'h00;
	assign sum_add = sum + {10'h000, p_mag};
	assign pi_sum = {1'b0, p_pos} + {1'b0, integ};

	// next values; the law steps once per update tick, while disable clears them at once
	always_comb
	begin
		next_on = on;
		next_pct = pct;
		next_sum = sum;
		next_integ = integ;
		if (!enable)
		begin
			next_on = 1'b0;
			next_pct = 7'h00;
			next_sum = 17'h00000;
			next_integ = 7'h00;
		end
		else if (tick)
		begin
			unique case (mode)
				rtcl_pkg::RTCL_TWO_POINT:
				begin
					if (late)
					begin
						if (e_pos)
							next_on = 1'b1;
						else if (err <= -hyst_s)
							next_on = 1'b0;
					end
					else
					begin
						if (err > hyst_s)
							next_on = 1'b1;
						else if (!e_pos)
							next_on = 1'b0;
					end
					next_pct = next_on ? rtcl_pkg::FULL_PCT : 7'h00;
					next_sum = 17'h00000;
					next_integ = 7'h00;
				end
				rtcl_pkg::RTCL_PROP:
				begin
					next_pct = p_pos;
					next_on = (p_pos != 7'h00);
					next_sum = 17'h00000;
					next_integ = 7'h00;
				end
				rtcl_pkg::RTCL_PI:
				begin
					// integral moves at most 1 % per tick; zero deviation holds it
					if (e_pos || e_neg)
					begin
						if (sum_add >= {1'b0, tint})
						begin
							next_sum = sum_add - {1'b0, tint};
							if (e_pos)
								next_integ = (integ >= rtcl_pkg::FULL_PCT) ? integ : integ + 7'h01;
							else
								next_integ = (integ == 7'h00) ? integ : integ - 7'h01;
						end
						else
							next_sum = sum_add;
					end
					// first tick after entry has integ zero, so output equals p
					if (pi_sum > {1'b0, rtcl_pkg::FULL_PCT})
						next_pct = rtcl_pkg::FULL_PCT;
					else
						next_pct = pi_sum[6:0];
					next_on = (next_pct != 7'h00);
				end
				default:
				begin
					next_on = 1'b0;
					next_pct = 7'h00;
					next_sum = 17'h00000;
					next_integ = 7'h00;
				end
			endcase
		end
	end

	// stage state
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			on <= 1'b0;
			pct <= 7'h00;
			sum <= 17'h00000;
			integ <= 7'h00;
		end
		else
		begin
			on <= next_on;
			pct <= next_pct;
			sum <= next_sum;
			integ <= next_integ;
		end
	end
endmodule : rtcl_stage
`default_nettype wire

// ---- core/rtcl_top.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module rtcl_top #(
	parameter int UPD_CYC = rtcl_pkg::UPDATE_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// actuator demands
	output logic             heat_on,
	output logic             cool_on,
	output logic             add_on,
	output logic [6:0]       heat_pct,
	output logic [6:0]       cool_pct,
	output logic [6:0]       add_pct
);
	localparam int CW = $clog2(UPD_CYC);
	localparam int EW = rtcl_pkg::ERR_W;

	// byte-lane merge for register writes
	function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction : wmerge

	// sign-extend a temperature to deviation width
	function automatic logic signed [EW-1:0] sx(input logic [15:0] v);
		return $signed({{(EW-16){v[15]}}, v});
	endfunction : sx

	// magnitude of a signed hysteresis
	function automatic logic [15:0] mag(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction : mag

	// ========================================
	// register bus state
	logic                        aw_hold, next_aw_hold;
	logic [7:0]                  aw_addr, next_aw_addr;
	logic                        w_hold, next_w_hold;
	logic [31:0]                 w_data, next_w_data;
	logic [3:0]                  w_strb, next_w_strb;
	logic                        bvalid, next_bvalid;
	logic [1:0]                  bresp, next_bresp;
	logic                        rvalid, next_rvalid;
	logic [1:0]                  rresp, next_rresp;
	logic [31:0]                 rdata, next_rdata;
	logic                        wr_fire;
	logic                        wr_hit;
	logic [7:0]                  wr_addr;
	logic [7:0]                  rd_addr;
	logic [31:0]                 rd_word;
	logic                        rd_hit;
	// software registers
	logic [rtcl_pkg::CTRL_W-1:0] ctrl, next_ctrl;
	logic [15:0]                 setpt, next_setpt;
	logic [15:0]                 actual, next_actual;
	logic [15:0]                 band, next_band;
	logic [15:0]                 tint, next_tint;
	logic [15:0]                 deadz, next_deadz;
	logic [15:0]                 hyst_heat, next_hyst_heat;
	logic [15:0]                 hyst_cool, next_hyst_cool;
	logic [15:0]                 hyst_add, next_hyst_add;
	logic [15:0]                 add_ofs, next_add_ofs;
	// control law
	logic [CW-1:0]               tick_cnt, next_tick_cnt;
	logic                        tick;
	rtcl_pkg::rtcl_mode_e        heat_mode, cool_mode, add_mode;
	logic [16:0]                 widen;
	logic signed [EW-1:0]        cool_sp;
	logic signed [EW-1:0]        err_heat, err_cool, err_add;
	logic                        heat_zone, cool_zone;
	logic                        run;
	logic [5:0]                  status;

	// ========================================
	// axi4-lite handshakes; address and data may come in either order
	assign s_axi_awready = !aw_hold;
	assign s_axi_wready = !w_hold;
	assign s_axi_arready = !rvalid; // one read at a time
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign wr_fire = aw_hold && w_hold && !bvalid;
	assign wr_addr = {aw_addr[7:2], 2'h0};
	assign rd_addr = {s_axi_araddr[7:2], 2'h0};
	assign wr_hit = (wr_addr <= rtcl_pkg::A_ADD_OFS);

	// read decode; status words are read-only
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (rd_addr)
			rtcl_pkg::A_CTRL: rd_word = 32'(ctrl);
			rtcl_pkg::A_SETPT: rd_word = {16'h0000, setpt};
			rtcl_pkg::A_ACTUAL: rd_word = {16'h0000, actual};
			rtcl_pkg::A_BAND: rd_word = {16'h0000, band};
			rtcl_pkg::A_TINT: rd_word = {16'h0000, tint};
			rtcl_pkg::A_DEADZ: rd_word = {16'h0000, deadz};
			rtcl_pkg::A_HYST_HEAT: rd_word = {16'h0000, hyst_heat};
			rtcl_pkg::A_HYST_COOL: rd_word = {16'h0000, hyst_cool};
			rtcl_pkg::A_HYST_ADD: rd_word = {16'h0000, hyst_add};
			rtcl_pkg::A_ADD_OFS: rd_word = {16'h0000, add_ofs};
			rtcl_pkg::A_STATUS: rd_word = 32'(status);
			rtcl_pkg::A_OUT_PCT:
			begin
				rd_word[rtcl_pkg::OUT_HEAT_LSB +: 7] = heat_pct;
				rd_word[rtcl_pkg::OUT_COOL_LSB +: 7] = cool_pct;
				rd_word[rtcl_pkg::OUT_ADD_LSB +: 7] = add_pct;
			end
			rtcl_pkg::A_COOL_SP: rd_word = 32'(cool_sp);
			default: rd_hit = 1'b0;
		endcase
	end

	// bus channel next values
	always_comb
	begin
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (s_axi_awvalid && !aw_hold)
		begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold)
		begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (wr_fire)
		begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? rtcl_pkg::RESP_OKAY : rtcl_pkg::RESP_SLVERR;
		end
		if (s_axi_arvalid && !rvalid)
		begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = rd_hit ? rtcl_pkg::RESP_OKAY : rtcl_pkg::RESP_SLVERR;
		end
		else if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
	end

	// register file next values
	always_comb
	begin
		next_ctrl = ctrl;
		next_setpt = setpt;
		next_actual = actual;
		next_band = band;
		next_tint = tint;
		next_deadz = deadz;
		next_hyst_heat = hyst_heat;
		next_hyst_cool = hyst_cool;
		next_hyst_add = hyst_add;
		next_add_ofs = add_ofs;
		if (wr_fire)
		begin
			case (wr_addr)
				rtcl_pkg::A_CTRL:
					next_ctrl = rtcl_pkg::CTRL_W'(wmerge(32'(ctrl), w_data, w_strb));
				rtcl_pkg::A_SETPT: next_setpt = 16'(wmerge({16'h0000, setpt}, w_data, w_strb));
				rtcl_pkg::A_ACTUAL: next_actual = 16'(wmerge({16'h0000, actual}, w_data, w_strb));
				rtcl_pkg::A_BAND: next_band = 16'(wmerge({16'h0000, band}, w_data, w_strb));
				rtcl_pkg::A_TINT: next_tint = 16'(wmerge({16'h0000, tint}, w_data, w_strb));
				rtcl_pkg::A_DEADZ: next_deadz = 16'(wmerge({16'h0000, deadz}, w_data, w_strb));
				rtcl_pkg::A_HYST_HEAT:
					next_hyst_heat = 16'(wmerge({16'h0000, hyst_heat}, w_data, w_strb));
				rtcl_pkg::A_HYST_COOL:
					next_hyst_cool = 16'(wmerge({16'h0000, hyst_cool}, w_data, w_strb));
				rtcl_pkg::A_HYST_ADD:
					next_hyst_add = 16'(wmerge({16'h0000, hyst_add}, w_data, w_strb));
				rtcl_pkg::A_ADD_OFS:
					next_add_ofs = 16'(wmerge({16'h0000, add_ofs}, w_data, w_strb));
				default: ;
			endcase
		end
	end

	// bus and register state
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_hold <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= rtcl_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= rtcl_pkg::RESP_OKAY;
			rdata <= 32'h00000000;
			ctrl <= rtcl_pkg::CTRL_RST;
			setpt <= rtcl_pkg::SETPT_RST;
			actual <= rtcl_pkg::ACTUAL_RST;
			band <= rtcl_pkg::BAND_RST;
			tint <= rtcl_pkg::TINT_RST;
			deadz <= rtcl_pkg::DEADZ_RST;
			hyst_heat <= rtcl_pkg::HH_RST;
			hyst_cool <= rtcl_pkg::HC_RST;
			hyst_add <= rtcl_pkg::HA_RST;
			add_ofs <= rtcl_pkg::ADD_OFS_RST;
		end
		else
		begin
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			ctrl <= next_ctrl;
			setpt <= next_setpt;
			actual <= next_actual;
			band <= next_band;
			tint <= next_tint;
			deadz <= next_deadz;
			hyst_heat <= next_hyst_heat;
			hyst_cool <= next_hyst_cool;
			hyst_add <= next_hyst_add;
			add_ofs <= next_add_ofs;
		end
	end

	// ========================================
	// update tick; law evaluates once per period
	assign tick = (tick_cnt == '0);
	assign next_tick_cnt = tick ? CW'(UPD_CYC - 1) : tick_cnt - 1'b1;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			tick_cnt <= '0;
		else
			tick_cnt <= next_tick_cnt;
	end

	// ========================================
	// dead zone and deviations
	assign heat_mode = rtcl_pkg::rtcl_mode_e'(ctrl[rtcl_pkg::CTRL_HM_LSB +: 2]);
	assign cool_mode = rtcl_pkg::rtcl_mode_e'(ctrl[rtcl_pkg::CTRL_CM_LSB +: 2]);
	assign add_mode = rtcl_pkg::rtcl_mode_e'(ctrl[rtcl_pkg::CTRL_AM_LSB +: 2]);
	assign run = ctrl[rtcl_pkg::CTRL_EN_BIT];
	// only the heat and cool stages, when two-point, add their hysteresis to the dead zone
	assign widen = ((heat_mode == rtcl_pkg::RTCL_TWO_POINT) ? {1'b0, mag(hyst_heat)} : 17'h00000)
		+ ((cool_mode == rtcl_pkg::RTCL_TWO_POINT) ? {1'b0, mag(hyst_cool)} : 17'h00000);
	assign cool_sp = sx(setpt) + $signed({3'h0, deadz}) + $signed({2'h0, widen});
	assign err_heat = sx(setpt) - sx(actual);
	assign err_cool = sx(actual) - cool_sp;
	assign err_add = sx(setpt) - $signed({3'h0, add_ofs}) - sx(actual);
	assign heat_zone = (sx(actual) < sx(setpt));
	assign cool_zone = (sx(actual) > cool_sp);

	// status word
	always_comb
	begin
		status = 6'h00;
		status[rtcl_pkg::ST_HEAT_ON] = heat_on;
		status[rtcl_pkg::ST_COOL_ON] = cool_on;
		status[rtcl_pkg::ST_ADD_ON] = add_on;
		status[rtcl_pkg::ST_HEAT_ZONE] = heat_zone;
		status[rtcl_pkg::ST_COOL_ZONE] = cool_zone;
		status[rtcl_pkg::ST_DEAD_ZONE] = !heat_zone && !cool_zone;
	end

	// ========================================
	// stages; heating is cut at the cooling set point and cooling at or below the heating set point
	rtcl_stage u_heat (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (tick),
		.enable  (run && !(sx(actual) >= cool_sp)),
		.mode    (heat_mode),
		.err     (err_heat),
		.band    (band),
		.tint    (tint),
		.hyst    (mag(hyst_heat)),
		.late    (!hyst_heat[15]),
		.pct     (heat_pct),
		.on      (heat_on)
	);

	rtcl_stage u_cool (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (tick),
		.enable  (run && (sx(actual) > sx(setpt))),
		.mode    (cool_mode),
		.err     (err_cool),
		.band    (band),
		.tint    (tint),
		.hyst    (mag(hyst_cool)),
		.late    (hyst_cool[15]),
		.pct     (cool_pct),
		.on      (cool_on)
	);

	rtcl_stage u_add (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (tick),
		.enable  (run && ctrl[rtcl_pkg::CTRL_ADD_EN_BIT] && !(sx(actual) >= cool_sp)),
		.mode    (add_mode),
		.err     (err_add),
		.band    (band),
		.tint    (tint),
		.hyst    (mag(hyst_add)),
		.late    (!hyst_add[15]),
		.pct     (add_pct),
		.on      (add_on)
	);
endmodule : rtcl_top
`default_nettype wire

// ---- tb/rtcl_top_sva.sv ----
`default_nettype none
module rtcl_top_sva (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        srst,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// actuator demands
	input wire logic        heat_on,
	input wire logic        cool_on,
	input wire logic [6:0]  heat_pct,
	input wire logic [6:0]  cool_pct,
	input wire logic [6:0]  add_pct
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// ========================================
	// bus handshakes, split into take and answer steps
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer missing");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");

	// ========================================
	// actuator demands
	a_heat_range: assert property (heat_pct <= 7'h64)
		else $error("heat demand out of range");
	a_cool_range: assert property (cool_pct <= 7'h64)
		else $error("cool demand out of range");
	a_add_range: assert property (add_pct <= 7'h64)
		else $error("extra demand out of range");
	a_no_both: assert property (!(heat_on && cool_on))
		else $error("heat and cool together");
endmodule : rtcl_top_sva
`default_nettype wire

// ---- tb/rtcl_room.sv ----
`default_nettype none
module rtcl_room #(
	parameter int LAG = 3 // larger is a slower room
) (
	// clock and reset
	input wire logic          clk_sys,
	input wire logic          srst,
	// actuator demands
	input wire logic [6:0]    heat_pct,
	input wire logic [6:0]    cool_pct,
	// sensed temperature, lsb 0.01 K
	output logic signed [15:0] temp
);
	// ========================================
	// heat balance: a steady loss keeps heating busy
	always_ff @(posedge clk_sys)
		if (srst)
			temp <= 16'sh0800;
		else
			temp <= temp + 16'(heat_pct >> LAG) - 16'(cool_pct >> LAG) - 16'sh0001;
endmodule : rtcl_room
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UPD = 8;
	// ========================================
	// wiring and bench state
	logic clk_sys, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, heat_on, cool_on, add_on, ho, co, ao;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [6:0] heat_pct, cool_pct, add_pct, hp, cp, ap, v;
	logic signed [15:0] room_t;
	int num_errors, check_count, a;
	int cn[6] = '{1700, 1701, 2100, 2101, 2099, 2900};
	logic [15:0] rv[10] = '{16'h0308, 16'h0834, 16'h0834, 16'h0190, 16'h00B4,
		16'h0190, 16'h0064, 16'hFF9C, 16'hFFCE, 16'h0064};
	rtcl_top #(.UPD_CYC(UPD)) i_dut (.*);
	rtcl_room i_room (.clk_sys, .srst, .heat_pct, .cool_pct, .temp(room_t));

	// ========================================
	// helpers
	function automatic logic [6:0] p_exp(input int d);
		return d <= 0 ? 7'h00 : d >= 400 ? 7'h64 : 7'(d * 100 / 400);
	endfunction : p_exp
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// ready is raised after a random lag so held answers get exercised
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic aw_ok, w_ok, b_ok;
		int n, lag;
		lag = $urandom_range(2);
		n = 0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			#1;
			aw_ok = s_axi_awready;
			w_ok = s_axi_wready;
			b_ok = s_axi_bvalid && s_axi_bready;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			n++;
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			s_axi_bready <= n >= lag && !b_ok;
		end
		while (!b_ok);
		@(posedge clk_sys);
	endtask : wr
	task automatic rd_reg(input logic [7:0] ad);
		logic r_ok, ar_ok;
		int n, lag;
		lag = $urandom_range(2);
		n = 0;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		do
		begin
			#1;
			ar_ok = s_axi_arready;
			r_ok = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			n++;
			// address is only released on the edge that took it
			if (ar_ok) s_axi_arvalid <= 1'b0;
			s_axi_rready <= n >= lag && !r_ok;
		end
		while (!r_ok);
		@(posedge clk_sys);
	endtask : rd_reg
	// outputs are snapped mid-cycle, well clear of the updating edge
	task automatic tk();
		repeat (2 * UPD + 3) @(posedge clk_sys);
		@(negedge clk_sys);
		{ho, co, ao, hp, cp, ap} = {heat_on, cool_on, add_on, heat_pct, cool_pct, add_pct};
		@(posedge clk_sys);
	endtask : tk
	task automatic tp(input logic [31:0] c, input logic [7:0] ha, input logic [31:0] h,
		input int base, input int sg, input int d[6], input int e[6]);
		wr(8'h00, c);
		wr(ha, h);
		foreach (d[i])
		begin
			wr(8'h08, 32'(base + sg * d[i]));
			tk();
			chk("two point on", e[i], ha == 8'h20 ? ao : sg > 0 ? co : ho);
			chk("two point pct", e[i] ? 100 : 0, ha == 8'h20 ? ap : sg > 0 ? cp : hp);
		end
	endtask : tp
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// ========================================
	// clock, watchdog and main sequence
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		#200000;
		num_errors++;
		$display("wrong value watchdog exp done got hang");
		finish_test();
	end
	initial
	begin
		{srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
		num_errors = 0;
		check_count = 0;
		void'($urandom(32'h988D8735));
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		foreach (rv[i])
		begin
			rd_reg(8'(4 * i));
			chk("reset value", {16'h0, rv[i]}, rd);
		end
		rd_reg(8'h30);
		chk("cool set point", 2600, rd);
		rd_reg(8'h40);
		chk("unmapped resp", rtcl_pkg::RESP_SLVERR, rsp);
		chk("unmapped data", 0, rd);
		wr(8'h28, 32'hFF);
		chk("read only resp", rtcl_pkg::RESP_SLVERR, rsp);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h00, i == 0 ? 32'h135 : i == 1 ? 32'h131 : 32'h130);
			tk();
			rd_reg(8'h30);
			chk("cool set point", 2500 + 100 * i, rd);
		end
		// proportional heat and cool: corners, random, then the room closes the loop
		wr(8'h00, 32'h135);
		for (int i = 0; i < 24; i++)
		begin
			a = i < 6 ? cn[i] : i < 16 ? 1200 + $urandom_range(1800) : room_t;
			wr(8'h08, 32'(a));
			tk();
			chk("heat pct", p_exp(2100 - a), hp);
			chk("cool pct", p_exp(a - 2500), cp);
		end
		tp(32'h13C, 8'h18, 32'h64, 2100, -1, '{50, -50, -100, -50, 0, 1}, '{1, 1, 0, 0, 0, 1});
		tp(32'h13C, 8'h18, 32'hFF9C, 2100, -1, '{50, 0, 50, 100, 101, 50}, '{1, 0, 0, 0, 1, 1});
		tp(32'h133, 8'h1C, 32'hFF9C, 2600, 1, '{50, -50, -100, -50, 1, 0}, '{1, 1, 0, 0, 1, 1});
		// extra stage alone, negative hysteresis around set point minus offset
		tp(32'h30F, 8'h20, 32'hFFCE, 2000, -1, '{100, 0, 25, 50, 51, 10}, '{1, 0, 0, 0, 1, 1});
		// integral: first answer is the proportional share, then it climbs and holds
		wr(8'h10, 32'h1);
		wr(8'h08, 32'd1900);
		wr(8'h00, 32'h03E);
		wr(8'h00, 32'h13E);
		@(negedge clk_sys);
		a = 0;
		while (heat_pct === 7'h00 && a < 40)
		begin
			@(negedge clk_sys);
			a++;
		end
		chk("pi first", 50, heat_pct);
		@(posedge clk_sys);
		repeat (3) tk();
		chk("pi climb", 1, hp > 7'h32);
		wr(8'h08, 32'd2100);
		tk();
		v = hp;
		tk();
		chk("pi hold", v, hp);
		chk("pi keep", 1, v > 7'h00);
		// at the set point the room sits in the dead zone with heating still held on
		rd_reg(8'h28);
		chk("status", 32'h21, rd);
		rd_reg(8'h2C);
		chk("out word", 32'(v), rd);
		finish_test();
	end
endmodule : tb_top
bind rtcl_top rtcl_top_sva i_sva (.*);
`default_nettype wire
